// ===== core/iect_timer.sv
// Sixteen bit interval and external event count timer with APB registers
// Functional notes
// RULE1: Channel match at or below period: irq and toggle
// RULE2: Channel output mirrors primary period, phase shifted
// RULE3: Channel above period: no irq, no toggle
// RULE4: Event-driven interval needs first edge to start
// RULE5: Compares at 0001H toggle every two counts
// RULE6: External event enable only for event-driven outputs
// RULE7: Mode 001 counts edges, period irq
// RULE8: Event count mode drives no output pins
// RULE9: Enable clears FFFFH to 0000H, loads period buffer
// RULE10: Period match clears counter, raises period irq
// RULE11: Period irq after D plus one events
// RULE12: Channel compares still active; software masks them
// RULE13: Software never programs period zero in event mode
// RULE14: Software selects interval mode, then sets event enable
// RULE15: Event clock only from pin; capture select zero
// RULE16: Period FFFFH wraps with irq, no overflow flag
// RULE17: Software stops counter before lowering period
// RULE18: Period write copies to buffer at once
// RULE19: Capture select and overflow ignored in event mode
// RULE20: Interval period match clears, toggles, raises irq
// RULE21: Disabled counter sits FFFFH, read buffer gives 0000H
// RULE22: Event pin synchronised, one pulse per edge
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module iect_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        event_input_pin,
   output logic             primary_timer_out,
   output logic [2:0]       channel_timer_out,
   output logic [3:0]       timer_out_en,
   output logic             period_match_irq,
   output logic [2:0]       channel_match_irq
);
   iect_pkg::iect_cfg_t cfg_ff;
   iect_pkg::iect_irq_t irq_ff;
   iect_pkg::iect_irq_t nxt_irq;

   logic [15:0] period_compare_reg_ff;
   logic [15:0] chan_reg_ff [3];
   logic [15:0] period_compare_buffer_ff;
   logic [15:0] chan_buf_ff [3];
   logic [15:0] counter_ff;
   logic [15:0] nxt_counter;
   logic [2:0]  mask_ff;
   logic        overflow_flag_ff;
   logic        first_ff;
   logic        ce_prev_ff;
   logic [3:0]  div_ff;
   logic        prim_ff;
   logic [2:0]  chan_out_ff;
   logic [3:0]  oe_ff;
   logic        ready_ff;
   logic [31:0] rdata_ff;
   logic        err_ff;

   logic        evt_pulse;
   logic        int_tick;
   logic        tick;
   logic        evmode;
   logic        use_events;
   logic        period_hit;
   logic        wrap_ovf;
   logic        start;
   logic        wr_en;
   logic        rd_en;
   logic        addr_ok;
   logic [2:0]  chan_hit;
   logic [31:0] nxt_rdata;

   iect_edge_det u_edge (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_in     (event_input_pin),
      .edge_sel   (cfg_ff.evt_sel),
      .edge_pulse (evt_pulse)
   );

   // APB: one wait state, so read data and error come from flops
   assign wr_en = psel & penable & ready_ff & pwrite;
   assign rd_en = psel & penable & ~ready_ff & ~pwrite;

   always_comb begin
      addr_ok   = 1'b1;
      nxt_rdata = 32'h0000_0000;
      case (paddr)
         iect_pkg::OFS_CTL0: nxt_rdata[iect_pkg::CTL0_CE_BIT] = cfg_ff.ce;
         iect_pkg::OFS_CTL1: begin
            nxt_rdata[iect_pkg::CTL1_MD_LSB +: 3] = cfg_ff.mode;
            nxt_rdata[iect_pkg::CTL1_EEE_BIT]     = cfg_ff.eee;
         end
         iect_pkg::OFS_IOC: begin
            nxt_rdata[iect_pkg::IOC_CAP_LSB +: 2] = cfg_ff.cap_sel;
            nxt_rdata[iect_pkg::IOC_EVT_LSB +: 2] = cfg_ff.evt_sel;
         end
         iect_pkg::OFS_OPT0: nxt_rdata[iect_pkg::OPT0_OVF_BIT] = overflow_flag_ff;
         iect_pkg::OFS_PERIOD_COMPARE_BUFFER: nxt_rdata[15:0] = period_compare_reg_ff;
         iect_pkg::OFS_CCR1: nxt_rdata[15:0] = chan_reg_ff[0];
         iect_pkg::OFS_CCR2: nxt_rdata[15:0] = chan_reg_ff[1];
         iect_pkg::OFS_CCR3: nxt_rdata[15:0] = chan_reg_ff[2];
         // Read buffer shows zero while stopped RULE21
         iect_pkg::OFS_CNT:  nxt_rdata[15:0] = cfg_ff.ce ? counter_ff : iect_pkg::CNT_ZERO; // RULE21
         iect_pkg::OFS_MASK: nxt_rdata[iect_pkg::MASK_LSB +: 3] = mask_ff;
         default:            addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         err_ff   <= 1'b0;
      end else begin
         ready_ff <= psel & penable & ~ready_ff;
         err_ff   <= psel & penable & ~ready_ff & ~addr_ok;
         if (rd_en) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign prdata  = rdata_ff;
   assign pready  = ready_ff;
   assign pslverr = err_ff;

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff  <= '0;
         mask_ff <= iect_pkg::MASK_RESET;
      end else if (wr_en) begin
         case (paddr)
            iect_pkg::OFS_CTL0: cfg_ff.ce <= pwdata[iect_pkg::CTL0_CE_BIT];
            iect_pkg::OFS_CTL1: begin
               cfg_ff.mode <= pwdata[iect_pkg::CTL1_MD_LSB +: 3];
               cfg_ff.eee  <= pwdata[iect_pkg::CTL1_EEE_BIT];
            end
            iect_pkg::OFS_IOC: begin
               cfg_ff.cap_sel <= pwdata[iect_pkg::IOC_CAP_LSB +: 2];
               cfg_ff.evt_sel <= pwdata[iect_pkg::IOC_EVT_LSB +: 2];
            end
            iect_pkg::OFS_MASK: mask_ff <= pwdata[iect_pkg::MASK_LSB +: 3];
            default: ;
         endcase
      end
   end

   // Compare registers hold software values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_compare_reg_ff <= iect_pkg::CCR_RESET;
         chan_reg_ff[0]        <= iect_pkg::CCR_RESET;
         chan_reg_ff[1]        <= iect_pkg::CCR_RESET;
         chan_reg_ff[2]        <= iect_pkg::CCR_RESET;
      end else if (wr_en) begin
         case (paddr)
            iect_pkg::OFS_PERIOD_COMPARE_BUFFER: period_compare_reg_ff <= pwdata[15:0];
            iect_pkg::OFS_CCR1: chan_reg_ff[0]        <= pwdata[15:0];
            iect_pkg::OFS_CCR2: chan_reg_ff[1]        <= pwdata[15:0];
            iect_pkg::OFS_CCR3: chan_reg_ff[2]        <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Count source selection; the event pin clocks the counter in event mode or with eee set, else the internal divider RULE15 RULE6
   assign evmode     = (cfg_ff.mode == iect_pkg::MODE_EVCOUNT);
   assign use_events = evmode | cfg_ff.eee; // RULE7 RULE15
   assign int_tick   = (div_ff == iect_pkg::CNT_DIV_LAST);
   assign tick       = cfg_ff.ce & (use_events ? evt_pulse : int_tick);
   assign start      = cfg_ff.ce & ~ce_prev_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff     <= 4'h0;
         ce_prev_ff <= 1'b0;
      end else begin
         ce_prev_ff <= cfg_ff.ce;
         if (!cfg_ff.ce || int_tick) begin
            div_ff <= 4'h0;
         end else begin
            div_ff <= div_ff + 4'h1;
         end
      end
   end

   // Buffers: anytime write, also loaded on enable RULE9 RULE18
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_compare_buffer_ff <= iect_pkg::CCR_RESET;
      end else if (start) begin
         period_compare_buffer_ff <= period_compare_reg_ff; // RULE9
      end else if (wr_en && paddr == iect_pkg::OFS_PERIOD_COMPARE_BUFFER) begin
         period_compare_buffer_ff <= pwdata[15:0]; // RULE18
      end
   end

   assign period_hit = ~first_ff & (counter_ff == period_compare_buffer_ff);
   // A plain wrap past FFFFH is an overflow; a period match at FFFFH is not RULE16
   assign wrap_ovf   = ~first_ff & ~period_hit & (counter_ff == iect_pkg::CNT_IDLE);

   always_comb begin
      if (first_ff) begin
         nxt_counter = iect_pkg::CNT_ZERO; // RULE4 RULE9
      end else if (period_hit) begin
         nxt_counter = iect_pkg::CNT_ZERO; // RULE10 RULE11 RULE20
      end else begin
         nxt_counter = counter_ff + 16'h0001; // RULE18
      end
   end

   // Counter waits at FFFFH until the first count edge after enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_ff <= iect_pkg::CNT_IDLE;
         first_ff   <= 1'b1;
      end else if (!cfg_ff.ce) begin
         counter_ff <= iect_pkg::CNT_IDLE; // RULE21
         first_ff   <= 1'b1;
      end else if (tick) begin
         counter_ff <= nxt_counter; // RULE4 RULE9
         first_ff   <= 1'b0;
      end
   end

   // Overflow flag only in interval mode, cleared by writing zero RULE19
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_ff <= 1'b0;
      end else if (tick && wrap_ovf && !evmode) begin
         overflow_flag_ff <= 1'b1; // RULE16 RULE19
      end else if (wr_en && paddr == iect_pkg::OFS_OPT0 && !pwdata[iect_pkg::OPT0_OVF_BIT]) begin
         overflow_flag_ff <= 1'b0;
      end
   end

   // One process owns the whole irq word so no member has two drivers
   always_comb begin
      nxt_irq.period = tick & period_hit; // RULE7 RULE10 RULE16 RULE20
      nxt_irq.chan   = chan_hit & ~mask_ff; // RULE12
   end

   // Primary output toggles on the first count tick after enable and on each period match in interval mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prim_ff <= 1'b0;
      end else if (tick && !evmode && (first_ff || period_hit)) begin
         prim_ff <= ~prim_ff; // RULE20
      end
   end

   // Secondary channels; a value above the period is never reached
   for (genvar k = 0; k < 3; k++) begin : g_chan
      logic hit;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            chan_buf_ff[k] <= iect_pkg::CCR_RESET;
         end else if (start) begin
            chan_buf_ff[k] <= chan_reg_ff[k]; // RULE12
         end else if (wr_en && paddr == iect_pkg::OFS_CCR1 + 8'(4 * k)) begin
            chan_buf_ff[k] <= pwdata[15:0]; // RULE12
         end
      end

      assign hit = tick & (nxt_counter == chan_buf_ff[k]); // RULE1 RULE3 RULE5

      assign chan_hit[k] = hit; // RULE1 RULE3

      // Toggle per match gives a square wave at the primary period RULE2
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            chan_out_ff[k] <= 1'b0;
         end else if (hit && !evmode) begin
            chan_out_ff[k] <= ~chan_out_ff[k]; // RULE1 RULE2 RULE5
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= '0;
         oe_ff  <= 4'h0;
      end else begin
         irq_ff <= nxt_irq;
         oe_ff  <= evmode ? 4'h0 : 4'hF; // RULE8
      end
   end

   assign primary_timer_out = prim_ff;
   assign channel_timer_out = chan_out_ff;
   assign timer_out_en      = oe_ff;
   assign period_match_irq  = irq_ff.period;
   assign channel_match_irq = irq_ff.chan;
endmodule

// ===== core/iect_pkg.sv
// Package with constants and types for the interval and event count timer
package iect_pkg;

   localparam int unsigned APB_AW = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_CTL0 = 8'h00;
   localparam logic [7:0] OFS_CTL1 = 8'h04;
   localparam logic [7:0] OFS_IOC  = 8'h08;
   localparam logic [7:0] OFS_OPT0 = 8'h0C;
   localparam logic [7:0] OFS_PERIOD_COMPARE_BUFFER = 8'h10;
   localparam logic [7:0] OFS_CCR1 = 8'h14;
   localparam logic [7:0] OFS_CCR2 = 8'h18;
   localparam logic [7:0] OFS_CCR3 = 8'h1C;
   localparam logic [7:0] OFS_CNT  = 8'h20;
   localparam logic [7:0] OFS_MASK = 8'h24;

   // Field positions
   localparam int unsigned CTL0_CE_BIT  = 0;
   localparam int unsigned CTL1_MD_LSB  = 0;
   localparam int unsigned CTL1_EEE_BIT = 3;
   localparam int unsigned IOC_CAP_LSB  = 0;
   localparam int unsigned IOC_EVT_LSB  = 2;
   localparam int unsigned OPT0_OVF_BIT = 0;
   localparam int unsigned MASK_LSB     = 1;

   // Mode field encodings
   localparam logic [2:0] MODE_INTERVAL = 3'h0;
   localparam logic [2:0] MODE_EVCOUNT  = 3'h1;

   // Event edge select encodings
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Reset and boundary values
   localparam logic [15:0] CNT_IDLE  = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO  = 16'h0000;
   localparam logic [15:0] CCR_RESET = 16'h0000;
   localparam logic [2:0]  MASK_RESET = 3'h7;

   // Internal count clock: pclk 50 ns, count clock period 100 ns
   localparam int unsigned PCLK_NS      = 50;
   localparam int unsigned CNT_CLK_NS   = 100;
   localparam int unsigned CNT_DIV      = (CNT_CLK_NS + PCLK_NS - 1) / PCLK_NS;
   localparam logic [3:0]  CNT_DIV_LAST = 4'(CNT_DIV - 1);

   typedef struct packed {
      logic       ce;
      logic [2:0] mode;
      logic       eee;
      logic [1:0] cap_sel;
      logic [1:0] evt_sel;
   } iect_cfg_t;

   typedef struct packed {
      logic       period;
      logic [2:0] chan;
   } iect_irq_t;

endpackage

// ===== core/iect_edge_det.sv
// Event pin synchroniser and valid edge detector
`timescale 1ns/1ps
module iect_edge_det (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       pin_in,
   input  wire logic [1:0] edge_sel,
   output logic            edge_pulse
);
   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;
   logic nxt_pulse;

   // Two flops before any logic looks at the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff  <= 1'b0;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   always_comb begin
      case (edge_sel)
         iect_pkg::EDGE_RISE: nxt_pulse = sync2_ff & ~prev_ff;
         iect_pkg::EDGE_FALL: nxt_pulse = ~sync2_ff & prev_ff;
         iect_pkg::EDGE_BOTH: nxt_pulse = sync2_ff ^ prev_ff;
         default:             nxt_pulse = 1'b0;
      endcase
   end

   // One pulse per detected edge RULE22
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= nxt_pulse; // RULE22
      end
   end
endmodule

// ===== verification/iect_sva.sv
// Concurrent checks on the timer's ports
`timescale 1ns/1ps
module iect_sva (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic       primary_timer_out,
   input wire logic [2:0] channel_timer_out,
   input wire logic [3:0] timer_out_en,
   input wire logic       period_match_irq,
   input wire logic [2:0] channel_match_irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not on second access cycle");
   apb_phase_a: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready outside access phase");
   apb_err_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   irq_pulse_a: assert property (period_match_irq |=> !period_match_irq)
      else $error("period irq longer than one cycle");
   ch_pulse_a: assert property (channel_match_irq[0] |=> !channel_match_irq[0])
      else $error("channel irq longer than one cycle");
   // Window either side: irq and toggle may sit one register stage apart
   prim_tgl_a: assert property (period_match_irq && timer_out_en[0]
      |-> ##[0:1] primary_timer_out != $past(primary_timer_out, 2))
      else $error("period match without primary toggle");
   ch1_tgl_a: assert property (channel_match_irq[0] && timer_out_en[1]
      |-> ##[0:1] channel_timer_out[0] != $past(channel_timer_out[0], 2))
      else $error("channel match without channel toggle");
   out_idle_a: assert property (timer_out_en == 4'h0
      |=> $stable(primary_timer_out) && $stable(channel_timer_out))
      else $error("outputs moved while not driven");
endmodule

bind iect_timer iect_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .primary_timer_out(primary_timer_out),
   .channel_timer_out(channel_timer_out), .timer_out_en(timer_out_en),
   .period_match_irq(period_match_irq), .channel_match_irq(channel_match_irq));

// ===== verification/iect_evt_src.sv
// External event source model for the timer's event pin
`timescale 1ns/1ps
module iect_evt_src (
   input  wire logic pclk,
   output logic      pin
);
   initial pin = 1'b0;
   // Levels held at least one pclk, else the synchroniser may drop edges
   task automatic pulses(input int n, input int hold);
      repeat (n) begin
         @(posedge pclk);
         pin <= 1'b1;
         repeat (hold) @(posedge pclk);
         pin <= 1'b0;
         repeat (hold) @(posedge pclk);
      end
   endtask
endmodule

// ===== verification/iect_timer_tb.sv
// Self-checking testbench for the interval and event count timer
`timescale 1ns/1ps
module iect_timer_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        evt, prim, pirq;
   logic [2:0]  chan, cirq;
   logic [3:0]  oen;
   int          err_count, checks_done, pirq_n, c1_n, c3_n, p_tgl, c1_tgl, c3_tgl;

   iect_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_input_pin(evt), .primary_timer_out(prim), .channel_timer_out(chan), .timer_out_en(oen),
      .period_match_irq(pirq), .channel_match_irq(cirq));
   iect_evt_src src (.pclk(pclk), .pin(evt));

   initial pclk = 1'b0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      pirq_n += int'(pirq);
      c1_n += int'(cirq[0]);
      c3_n += int'(cirq[2]);
   end
   always @(prim) p_tgl++;
   always @(chan[0]) c1_tgl++;
   always @(chan[2]) c3_tgl++;

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
   endtask
   task automatic clr();
      pirq_n = 0;
      c1_n = 0;
      c3_n = 0;
      p_tgl = 0;
      c1_tgl = 0;
      c3_tgl = 0;
   endtask

   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd(iect_pkg::OFS_PERIOD_COMPARE_BUFFER, 32'h0000_0000);
      rd(iect_pkg::OFS_MASK, 32'h0000_000E);
      rd(iect_pkg::OFS_CNT, 32'h0000_0000);
      apb(1'b0, 8'h30, 32'h0000_0000, r, e);
      chk(r, 32'h0000_0000);
      chk(e, 32'h0000_0001);
   endtask
   task automatic t_interval();
      int n;
      n = 200 / (4 * iect_pkg::CNT_DIV);
      wr(iect_pkg::OFS_PERIOD_COMPARE_BUFFER, 32'h0000_0003);
      wr(iect_pkg::OFS_CCR1, 32'h0000_0001);
      wr(iect_pkg::OFS_CCR3, 32'h0000_0005);
      wr(iect_pkg::OFS_MASK, 32'h0000_0000);
      clr();
      wr(iect_pkg::OFS_CTL0, 32'h0000_0001);
      repeat (200) @(posedge pclk);
      chk(oen, 32'h0000_000F);
      chk(pirq_n inside {[n - 2 : n]}, 1'b1);
      chk((c1_n - pirq_n) inside {[0 : 1]}, 1'b1);
      chk((c1_tgl - p_tgl) inside {[-1 : 1]}, 1'b1);
      chk(c3_n, 0);
      chk(c3_tgl, 0);
      wr(iect_pkg::OFS_CTL0, 32'h0000_0000);
   endtask
   task automatic t_evcount();
      wr(iect_pkg::OFS_CTL1, 32'(iect_pkg::MODE_EVCOUNT));
      wr(iect_pkg::OFS_IOC, 32'({iect_pkg::EDGE_RISE, 2'h3}));
      wr(iect_pkg::OFS_PERIOD_COMPARE_BUFFER, 32'h0000_0002);
      wr(iect_pkg::OFS_MASK, 32'h0000_000C);
      clr();
      wr(iect_pkg::OFS_CTL0, 32'h0000_0001);
      chk(oen, 4'h0);
      src.pulses(1, 3);
      rd(iect_pkg::OFS_CNT, 32'h0000_0000);
      src.pulses(3, 3);
      rd(iect_pkg::OFS_CNT, 32'h0000_0000);
      chk(pirq_n, 1);
      chk(c1_n, 1);
      src.pulses(3, 6);
      chk(pirq_n, 2);
      wr(iect_pkg::OFS_IOC, 32'({iect_pkg::EDGE_BOTH, 2'h0}));
      src.pulses(1, 3);
      rd(iect_pkg::OFS_CNT, 32'h0000_0002);
      wr(iect_pkg::OFS_IOC, 32'({iect_pkg::EDGE_NONE, 2'h0}));
      src.pulses(2, 3);
      rd(iect_pkg::OFS_CNT, 32'h0000_0002);
      wr(iect_pkg::OFS_IOC, 32'({iect_pkg::EDGE_FALL, 2'h0}));
      src.pulses(1, 3);
      rd(iect_pkg::OFS_CNT, 32'h0000_0000);
      chk(pirq_n, 3);
      wr(iect_pkg::OFS_CTL0, 32'h0000_0000);
      rd(iect_pkg::OFS_CNT, 32'h0000_0000);
      rd(iect_pkg::OFS_OPT0, 32'h0000_0000);
   endtask
   task automatic t_evinterval();
      wr(iect_pkg::OFS_CTL1, 32'(iect_pkg::MODE_INTERVAL));
      wr(iect_pkg::OFS_CTL1, 32'h0000_0008);
      wr(iect_pkg::OFS_IOC, 32'({iect_pkg::EDGE_RISE, 2'h0}));
      wr(iect_pkg::OFS_PERIOD_COMPARE_BUFFER, 32'h0000_0001);
      clr();
      wr(iect_pkg::OFS_CTL0, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      rd(iect_pkg::OFS_CNT, 32'h0000_FFFF);
      chk(p_tgl, 0);
      src.pulses(1, 3);
      rd(iect_pkg::OFS_CNT, 32'h0000_0000);
      src.pulses(8, 3);
      chk(c1_tgl, 4);
      chk(pirq_n, 4);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_interval();
      t_evcount();
      t_evinterval();
      stop_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      stop_test();
   end
endmodule
